//--- timer_pkg.sv
/*
 * Shared constants and types for the three-channel reload timer.
 * Assumes a 32-bit AHB-Lite register bus and a single 200 MHz system clock.
 */
package timer_pkg;

    // ==========================================================
    // Structure
    localparam int NUM_CH = 3;
    localparam int CNT_W = 32;
    localparam int CAP_CH = 2;
    localparam int IDX_W = 8;
    localparam int PRE_W = 8;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [31:0] IDX_PIN_CONTROL = 32'hFFFF_FE90;
    localparam logic [31:0] IDX_CHANNEL_START = 32'hFFFF_FE92;
    localparam logic [31:0] IDX_CAPTURE_CH2 = 32'hFFFF_FEB8;
    localparam logic [31:0] IDX_RELOAD [NUM_CH] = '{32'hFFFF_FE94, 32'h0FFF_FEA0, 32'h0FFF_FEAC};
    localparam logic [31:0] IDX_COUNTER [NUM_CH] = '{32'h0FFF_FE98, 32'h0FFF_FEA4, 32'h0FFF_FEB0};
    localparam logic [31:0] IDX_CONTROL [NUM_CH] = '{32'hFFFF_FE9C, 32'hFFFF_FEA8, 32'h0FFF_FEB4};

    // ==========================================================
    // Reset values
    localparam logic [CNT_W-1:0] RST_COUNT = 32'h0FFF_FFFF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_CTRL = 16'h0000;

    // ==========================================================
    // Control register field positions
    localparam int BIT_CAP_FLAG = 9;
    localparam int BIT_UNF = 8;
    localparam int BIT_CAP_HI = 7;
    localparam int BIT_CAP_LO = 6;
    localparam int BIT_UNDERFLOW_IRQ_EN = 5;
    localparam int BIT_EDGE_HI = 4;
    localparam int BIT_EDGE_LO = 3;
    localparam int BIT_CLK_HI = 2;
    localparam int BIT_DIR = 0;
    localparam int CTRL_USED_W = 10;

    // ==========================================================
    // Codes
    localparam logic [2:0] CLK_DIV4 = 3'h0;
    localparam logic [2:0] CLK_DIV16 = 3'h1;
    localparam logic [2:0] CLK_DIV64 = 3'h2;
    localparam logic [2:0] CLK_DIV256 = 3'h3;
    localparam logic [2:0] CLK_RTC = 3'h4;
    localparam logic [2:0] CLK_PIN = 3'h5;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] CAP_RSVD = 2'h1;
    localparam logic [PRE_W-1:0] MASK_DIV4 = 8'h03;
    localparam logic [PRE_W-1:0] MASK_DIV16 = 8'h0F;
    localparam logic [PRE_W-1:0] MASK_DIV64 = 8'h3F;
    localparam logic [PRE_W-1:0] MASK_DIV256 = 8'hFF;

    // Control fields in register bit order 9 down to 0
    typedef struct packed {
        logic capFlag;
        logic underflowFlag;
        logic capUse;
        logic capIrqEn;
        logic underflowIrqEn;
        logic [1:0] edgeSel;
        logic [2:0] clkSel;
    } chan_ctrl_t;

endpackage

//--- three_channel_reload_timer.sv
/*
 * Three-channel 32-bit auto-reload down timer with capture on channel 2.
 * Assumes a single AHB-Lite master, synchronous pin inputs, and a
 * system controller that drives the standby, PLL-change and stop inputs.
 */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps

module three_channel_reload_timer
    import timer_pkg::*;
#(
    parameter int NCH = timer_pkg::NUM_CH
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rtcTick,
    input wire logic standbyActive,
    input wire logic pllChange,
    input wire logic moduleStop,
    input wire logic timerPinIn,
    output logic timerPinOut,
    output logic timerPinOe,
    output logic [timer_pkg::NUM_CH-1:0] irqOut
);
    import timer_pkg::*;

    // ==========================================================
    // Helper functions
    function automatic logic idxHit(input logic [IDX_W-1:0] idx, input logic [31:0] reg_idx);
        idxHit = (idx == reg_idx[IDX_W-1:0]);
    endfunction
    function automatic logic divTick(input logic [PRE_W-1:0] cnt, input logic [PRE_W-1:0] mask);
        divTick = ((cnt & mask) == mask);
    endfunction
    // Edge decode shared by counting and capture
    function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
        if (sel[1])
            edgeHit = rise | fall;
        else if (sel == EDGE_FALL)
            edgeHit = fall;
        else
            edgeHit = rise;
    endfunction

    // ==========================================================
    // State
    logic [CNT_W-1:0] reload_q [NCH];
    logic [CNT_W-1:0] count_q [NCH];
    chan_ctrl_t ctrl_q [NCH];
    logic [NCH-1:0] start_q;
    logic pinDir_q;
    logic [CNT_W-1:0] capture_q;
    logic [PRE_W-1:0] preCnt_q;
    logic pinPrev_q;
    logic rtcPrev_q;
    logic dpWrite_q;
    logic [IDX_W-1:0] dpIdx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;
    logic timerPinOut_q;
    logic timerPinOe_q;
    logic [NCH-1:0] irqOut_q;
    logic addrValid;
    logic [IDX_W-1:0] addrIdx;
    logic lowPower;
    logic pinRise;
    logic pinFall;
    logic rtcRise;
    logic capEvent;
    logic [NCH-1:0] tick;
    logic [NCH-1:0] underflow;
    logic [NCH-1:0] wrReload;
    logic [NCH-1:0] wrCount;
    logic [NCH-1:0] wrCtrl;
    logic wrPin;
    logic wrStart;
    logic [31:0] readData;

    // ==========================================================
    // Bus slave: zero-wait, always OKAY
    assign addrValid = hsel & htrans[1] & hready;
    assign addrIdx = haddr[IDX_W+1:2];
    assign wrPin = dpWrite_q & idxHit(dpIdx_q, IDX_PIN_CONTROL);
    assign wrStart = dpWrite_q & idxHit(dpIdx_q, IDX_CHANNEL_START);
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;

    // Address phase capture; hsize is ignored since only word transfers occur
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dpWrite_q <= 1'b0;
            dpIdx_q <= '0;
            hreadyout_q <= 1'b0;
            hresp_q <= 1'b0;
        end
        else
        begin
            dpWrite_q <= addrValid & hwrite;
            dpIdx_q <= addrIdx;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end
    // Read mux; unmapped addresses and reserved bits read as zero
    always_comb
    begin
        readData = '0;
        if (idxHit(addrIdx, IDX_PIN_CONTROL))
            readData = {31'h0000_0000, pinDir_q};
        else if (idxHit(addrIdx, IDX_CHANNEL_START))
            readData = {{(32-NCH){1'b0}}, start_q};
        else if (idxHit(addrIdx, IDX_CAPTURE_CH2))
            readData = capture_q;
        for (int i = 0; i < NCH; i++)
        begin
            if (idxHit(addrIdx, IDX_RELOAD[i]))
                readData = reload_q[i];
            if (idxHit(addrIdx, IDX_COUNTER[i]))
                readData = count_q[i];
            if (idxHit(addrIdx, IDX_CONTROL[i]))
                readData = {{(32-CTRL_USED_W){1'b0}}, ctrl_q[i]};
        end
    end
    // Whole word is sampled in one edge, so halves never tear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            hrdata_q <= '0;
        else if (addrValid & ~hwrite)
            hrdata_q <= readData;
    end

    // ==========================================================
    // Clock sources: prescaler, RTC tick and pin edges
    assign lowPower = standbyActive | pllChange | moduleStop;
    assign pinRise = timerPinIn & ~pinPrev_q;
    assign pinFall = ~timerPinIn & pinPrev_q;
    assign rtcRise = rtcTick & ~rtcPrev_q;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            preCnt_q <= '0;
            pinPrev_q <= 1'b0;
            rtcPrev_q <= 1'b0;
        end
        else
        begin
            preCnt_q <= preCnt_q + 1'b1;
            pinPrev_q <= timerPinIn;
            rtcPrev_q <= rtcTick;
        end
    end
    // Pin direction and RTC output; pin control survives low power
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pinDir_q <= RST_BYTE[BIT_DIR];
            timerPinOut_q <= 1'b0;
            timerPinOe_q <= 1'b0;
        end
        else
        begin
            if (wrPin)
                pinDir_q <= hwdata[BIT_DIR];
            timerPinOut_q <= rtcTick;
            timerPinOe_q <= pinDir_q;
        end
    end
    assign timerPinOut = timerPinOut_q;
    assign timerPinOe = timerPinOe_q;

    // ==========================================================
    // Start register; low power halts only non-RTC channels
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            start_q <= RST_BYTE[NCH-1:0];
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (lowPower && ctrl_q[i].clkSel != CLK_RTC)
                    start_q[i] <= 1'b0;
                else if (wrStart)
                    start_q[i] <= hwdata[i];
            end
        end
    end

    // Capture needs the pin as input and the unit awake
    assign capEvent = ctrl_q[CAP_CH].capUse & ~pinDir_q & ~lowPower
        & edgeHit(ctrl_q[CAP_CH].edgeSel, pinRise, pinFall);

    // Capture holds no reset value by design
    always_ff @(posedge clk_sys)
    begin
        if (capEvent)
            capture_q <= count_q[CAP_CH];
    end

    // ==========================================================
    // Per-channel counter, reload and control
    for (genvar g = 0; g < NCH; g++)
    begin : gChan
        logic srcTick;
        assign wrReload[g] = dpWrite_q & idxHit(dpIdx_q, IDX_RELOAD[g]);
        assign wrCount[g] = dpWrite_q & idxHit(dpIdx_q, IDX_COUNTER[g]);
        assign wrCtrl[g] = dpWrite_q & idxHit(dpIdx_q, IDX_CONTROL[g]);
        // Reserved select codes never tick
        always_comb
        begin
            unique case (ctrl_q[g].clkSel)
                CLK_DIV4: srcTick = divTick(preCnt_q, MASK_DIV4);
                CLK_DIV16: srcTick = divTick(preCnt_q, MASK_DIV16);
                CLK_DIV64: srcTick = divTick(preCnt_q, MASK_DIV64);
                CLK_DIV256: srcTick = divTick(preCnt_q, MASK_DIV256);
                CLK_RTC: srcTick = rtcRise;
                CLK_PIN: srcTick = ~pinDir_q & edgeHit(ctrl_q[g].edgeSel, pinRise, pinFall);
                default: srcTick = 1'b0;
            endcase
        end
        assign tick[g] = start_q[g] & srcTick
            & (~lowPower | (ctrl_q[g].clkSel == CLK_RTC));
        assign underflow[g] = tick[g] & (count_q[g] == '0) & ~wrCount[g];
        // Bus write wins over a tick in the same cycle
        always_ff @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
            begin
                reload_q[g] <= RST_COUNT;
                count_q[g] <= RST_COUNT;
            end
            else
            begin
                if (wrReload[g])
                    reload_q[g] <= hwdata;
                if (wrCount[g])
                    count_q[g] <= hwdata;
                else if (underflow[g])
                    count_q[g] <= reload_q[g];
                else if (tick[g])
                    count_q[g] <= count_q[g] - 1'b1;
            end
        end
        // Flags: hardware set wins over a software clear
        always_ff @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
                ctrl_q[g] <= chan_ctrl_t'(RST_CTRL[CTRL_USED_W-1:0]);
            else
            begin
                if (wrCtrl[g])
                begin
                    ctrl_q[g].underflowIrqEn <= hwdata[BIT_UNDERFLOW_IRQ_EN];
                    ctrl_q[g].edgeSel <= hwdata[BIT_EDGE_HI:BIT_EDGE_LO];
                    ctrl_q[g].clkSel <= hwdata[BIT_CLK_HI:0];
                    if (g == CAP_CH && hwdata[BIT_CAP_HI:BIT_CAP_LO] != CAP_RSVD)
                    begin
                        ctrl_q[g].capUse <= hwdata[BIT_CAP_HI];
                        ctrl_q[g].capIrqEn <= hwdata[BIT_CAP_LO];
                    end
                end
                ctrl_q[g].underflowFlag <= underflow[g] | (ctrl_q[g].underflowFlag
                    & ~(wrCtrl[g] & ~hwdata[BIT_UNF]));
                if (g == CAP_CH)
                    ctrl_q[g].capFlag <= capEvent | (ctrl_q[g].capFlag
                        & ~(wrCtrl[g] & ~hwdata[BIT_CAP_FLAG]));
            end
        end
        // Level request while flag and enable both hold
        always_ff @(posedge clk_sys or negedge resetn)
        begin
            if (!resetn)
                irqOut_q[g] <= 1'b0;
            else
                irqOut_q[g] <= (ctrl_q[g].underflowFlag & ctrl_q[g].underflowIrqEn)
                    | (ctrl_q[g].capFlag & ctrl_q[g].capIrqEn);
        end

        // ======================================================
        // Checks
        reload_on_wrap_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            underflow[g] |=> count_q[g] == $past(reload_q[g]))
            else $error("counter did not reload on wrap");
        down_step_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            tick[g] && !wrCount[g] && count_q[g] != '0 |=> count_q[g] == $past(count_q[g]) - 1)
            else $error("counter did not step down by one");
        halted_hold_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            !start_q[g] && !wrCount[g] |=> $stable(count_q[g]))
            else $error("halted counter changed");
        flag_on_wrap_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            underflow[g] |=> ctrl_q[g].underflowFlag)
            else $error("underflow flag not set");
        irq_follows_flag_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            underflow[g] && ctrl_q[g].underflowIrqEn && !wrCtrl[g] |=> ##1 irqOut_q[g])
            else $error("interrupt missing after wrap");
        lowpower_halt_a: assert property (
            @(posedge clk_sys) disable iff (!resetn)
            lowPower && ctrl_q[g].clkSel != CLK_RTC |=> !start_q[g])
            else $error("start bit survived low power");
    end
    assign irqOut = irqOut_q;

    capture_copy_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        capEvent |=> capture_q == $past(count_q[CAP_CH]) && ctrl_q[CAP_CH].capFlag)
        else $error("capture did not copy counter 2");
    pin_output_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        pinDir_q |=> timerPinOe_q)
        else $error("pin not driven in output mode");
    reserved_zero_a: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        addrValid && !hwrite && idxHit(addrIdx, IDX_PIN_CONTROL) |=> hrdata_q[31:1] == '0)
        else $error("reserved pin control bits not zero");

endmodule

//--- timer_pin_source.sv
/* Model of the external clock or capture source on the timer pin.
   Assumes the bench resolves the pin level from this drive and the block enable. */
`timescale 1ns/1ps
module timer_pin_source
(
    input wire logic clk_sys,
    input wire logic blockOe,
    output logic pinDrive
);
    // ==========================================================
    // Pin pulses; the level stands low between bursts
    initial pinDrive = 1'b0;

    // A half period of 100 cycles or more keeps both-edge counts at 2 MHz
    task automatic pulse(input int n, input int half);
        repeat (n)
        begin
            pinDrive <= !blockOe; // No drive while the block owns the pin
            repeat (half) @(posedge clk_sys);
            pinDrive <= 1'b0;
            repeat (half) @(posedge clk_sys);
        end
    endtask
endmodule

//--- test_three_channel_reload_timer.sv
/* Self-checking bench for the three-channel reload timer.
   Assumes a single AHB-Lite slave answering with no wait states. */
`timescale 1ns/1ps
module test_three_channel_reload_timer;
    import timer_pkg::*;
    localparam int RTC_HALF = 6250;
    logic clk_sys = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rtcTick = 1'b0;
    logic standbyActive = 1'b0, pllChange = 1'b0, moduleStop = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, d;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, irqOut;
    logic hready, hreadyout, hresp, timerPinOut, timerPinOe, pinDrive, pinLevel;
    int n_errors = 0, total_checks = 0;

    // ==========================================================
    // Bus and pin wiring; the pin follows whoever enables it
    assign hready = hreadyout;
    assign pinLevel = timerPinOe ? timerPinOut : pinDrive;

    three_channel_reload_timer three_channel_reload_timer_inst
    (
        .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .rtcTick, .standbyActive, .pllChange, .moduleStop,
        .timerPinIn(pinLevel), .timerPinOut, .timerPinOe, .irqOut
    );

    timer_pin_source timer_pin_source_inst
    (
        .clk_sys, .blockOe(timerPinOe), .pinDrive
    );

    // Clock at 200 MHz
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // RTC tick near 16 kHz, moved on the clock edge
    always
    begin
        repeat (RTC_HALF) @(posedge clk_sys);
        rtcTick <= ~rtcTick;
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Register index to byte address, only the decoded bits kept
    function automatic logic [31:0] ad(input logic [31:0] idx);
        return {22'h0, idx[7:0], 2'b00};
    endfunction

    // One single word transfer; hangs are cut by the watchdog
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        xfer(1'b1, a, wd);
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the expected run of some 31k cycles
    initial
    begin
        #450000;
        n_errors++;
        end_sim();
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        // Reset values, then an unmapped place
        check({29'h0, irqOut}, 32'h0);
        rdc(ad(IDX_PIN_CONTROL), 32'h0000_0000);
        rdc(ad(IDX_CHANNEL_START), 32'h0000_0000);
        for (int c = 0; c < NUM_CH; c++)
        begin
            rdc(ad(IDX_RELOAD[c]), RST_COUNT);
            rdc(ad(IDX_COUNTER[c]), RST_COUNT);
            rdc(ad(IDX_CONTROL[c]), {16'h0, RST_CTRL});
        end
        wr(32'h0000_0300, 32'hFFFF_FFFF);
        rdc(32'h0000_0300, 32'h0000_0000);
        // Reserved bits, flags ignoring written ones, pin as output
        wr(ad(IDX_PIN_CONTROL), 32'hFFFF_FFFF);
        rdc(ad(IDX_PIN_CONTROL), 32'h0000_0001);
        check({31'h0, timerPinOe}, 32'h1);
        check({31'h0, timerPinOut}, {31'h0, rtcTick});
        wr(ad(IDX_CONTROL[0]), 32'hFFFF_FFFF);
        rdc(ad(IDX_CONTROL[0]), 32'h0000_003F);
        wr(ad(IDX_CONTROL[2]), 32'hFFFF_FFFF);
        rdc(ad(IDX_CONTROL[2]), 32'h0000_00FF);
        wr(ad(IDX_CONTROL[2]), 32'h0000_0040);
        rdc(ad(IDX_CONTROL[2]), 32'h0000_00C0);
        // Capture off again, or the pin-clock scenarios below would also capture
        wr(ad(IDX_CONTROL[2]), 32'h0000_0000);
        wr(ad(IDX_CHANNEL_START), 32'hFFFF_FFFF);
        rdc(ad(IDX_CHANNEL_START), 32'h0000_0007);
        wr(ad(IDX_PIN_CONTROL), 32'h0000_0000);
        wr(ad(IDX_CHANNEL_START), 32'h0000_0002);
        // Pin clock on channel 1 with every edge code
        for (int e = 0; e < 4; e++)
        begin
            wr(ad(IDX_CONTROL[1]), {27'h0, e[1:0], CLK_PIN});
            wr(ad(IDX_COUNTER[1]), 32'h0000_0100);
            timer_pin_source_inst.pulse(3, 100);
            rdc(ad(IDX_COUNTER[1]), e[1] ? 32'h0000_00FA : 32'h0000_00FD);
        end
        // Wrap, reload, sticky flag and its interrupt
        wr(ad(IDX_RELOAD[1]), 32'h0000_0007);
        wr(ad(IDX_COUNTER[1]), 32'h0000_0001);
        wr(ad(IDX_CONTROL[1]), 32'h0000_0025);
        timer_pin_source_inst.pulse(2, 100);
        rdc(ad(IDX_COUNTER[1]), 32'h0000_0007);
        check({29'h0, irqOut}, 32'h2);
        wr(ad(IDX_CONTROL[1]), 32'h0000_0125);
        rdc(ad(IDX_CONTROL[1]), 32'h0000_0125);
        wr(ad(IDX_CONTROL[1]), 32'h0000_0005);
        timer_pin_source_inst.pulse(1, 100);
        rdc(ad(IDX_COUNTER[1]), 32'h0000_0006);
        check({29'h0, irqOut}, 32'h0);
        wr(ad(IDX_COUNTER[1]), 32'h0000_0000);
        timer_pin_source_inst.pulse(1, 100);
        rdc(ad(IDX_CONTROL[1]), 32'h0000_0105);
        check({29'h0, irqOut}, 32'h0);
        // Capture on channel 2, halted so the copied value is known
        wr(ad(IDX_COUNTER[2]), 32'h1234_5678);
        wr(ad(IDX_CONTROL[2]), 32'h0000_00C3);
        timer_pin_source_inst.pulse(1, 100);
        rdc(ad(IDX_CAPTURE_CH2), 32'h1234_5678);
        rdc(ad(IDX_CONTROL[2]), 32'h0000_02C3);
        check({29'h0, irqOut}, 32'h4);
        wr(ad(IDX_CONTROL[2]), 32'h0000_0083);
        repeat (2) @(posedge clk_sys);
        check({29'h0, irqOut}, 32'h0);
        wr(ad(IDX_COUNTER[2]), 32'hA5A5_0000);
        timer_pin_source_inst.pulse(1, 100);
        rdc(ad(IDX_CAPTURE_CH2), 32'hA5A5_0000);
        check({29'h0, irqOut}, 32'h0);
        wr(ad(IDX_PIN_CONTROL), 32'h0000_0001);
        wr(ad(IDX_COUNTER[2]), 32'h0000_1111);
        timer_pin_source_inst.pulse(1, 100);
        rdc(ad(IDX_CAPTURE_CH2), 32'hA5A5_0000);
        wr(ad(IDX_PIN_CONTROL), 32'h0000_0000);
        // Divider ratios; fast codes run above the 2 MHz ceiling, only the ratio is checked
        for (int s = 0; s < 4; s++)
        begin
            wr(ad(IDX_CONTROL[0]), {29'h0, s[2:0]});
            wr(ad(IDX_CHANNEL_START), 32'h0000_0001);
            wr(ad(IDX_COUNTER[0]), 32'h0000_FFFF);
            repeat (1024) @(posedge clk_sys);
            wr(ad(IDX_CHANNEL_START), 32'h0000_0000);
            xfer(1'b0, ad(IDX_COUNTER[0]), 32'h0);
            d = 32'h0000_FFFF - rd + 32'h1 - 32'(1026 >> (2 * s + 2));
            check({31'h0, d <= 32'h2}, 32'h1);
        end
        // Low power: divided clock halts, RTC clock runs on; standby stays on last
        wr(ad(IDX_CONTROL[0]), 32'h0000_0003);
        wr(ad(IDX_CONTROL[1]), 32'h0000_0004);
        for (int m = 0; m < 3; m++)
        begin
            wr(ad(IDX_CHANNEL_START), 32'h0000_0003);
            {moduleStop, pllChange, standbyActive} <= 3'b100 >> m;
            @(posedge clk_sys);
            rdc(ad(IDX_CHANNEL_START), 32'h0000_0002);
            rdc(ad(IDX_CONTROL[0]), 32'h0000_0003);
            if (m < 2)
                {moduleStop, pllChange, standbyActive} <= 3'b000;
        end
        xfer(1'b0, ad(IDX_COUNTER[0]), 32'h0);
        d = rd;
        @(posedge rtcTick);
        @(posedge clk_sys);
        wr(ad(IDX_COUNTER[1]), 32'h0000_0050);
        @(posedge rtcTick);
        repeat (4) @(posedge clk_sys);
        rdc(ad(IDX_COUNTER[1]), 32'h0000_004F);
        check({31'h0, timerPinOut}, 32'h1);
        rdc(ad(IDX_COUNTER[0]), d);
        standbyActive <= 1'b0;
        end_sim();
    end
endmodule
